// ===== shared/ceb_regs.vh
// constants and register map of the completion record builder
// Notes on behaviour
// - each record is sixteen bytes, written as four 32-bit words zero to three
// - word zero carries the command result or zero; word one is always zero
// - word two bits 31:16 carry the submission ring identifier
// - word two bits 15:0 carry the consume pointer sampled at record creation
// - word three bits 31:17 hold the status word, bit 16 the freshness bit
// - word three bits 15:0 echo the command tag given by software
// - freshness bit written as one on first pass, inverted on every wrap
// - at most 64K outstanding on an I/O ring, 4K on the admin ring
// - bit 31 set means retry futile; cleared for time-limited recovery aborts
// - bit 30 set means more error detail is held in the error log
// - bits 29:28 zero, 27:25 status type, 24:17 status code
// - type 0 generic, 1 command specific, 2 media, 7 vendor; 3 to 6 reserved
// - codes up to 7Fh shared, 80h to BFh I/O set, C0h up vendor
// - of several applicable codes only the smallest is reported
// - generic 0 success with zero status word, 1,2,3 and Bh input faults
// - generic 4 transfer error, 5 power loss abort, 6 internal error
// - generic 7 to Ah explicit, ring deletion and fused command aborts
// - storage generic 80h range, 81h capacity, 82h namespace not ready
// - command specific 0,1,2 and 8h report ring creation faults
// - command specific 3h to Ah abort, event, firmware, log and format faults
// - storage command specific 80h conflicting attributes, 81h to BFh reserved
// - ring size is zero-based 16 bits, at least two slots, one kept unused
`ifndef CEB_REGS_VH
`define CEB_REGS_VH
`define CEB_REG_CTRL 8'h00
`define CEB_REG_SIZE 8'h04
`define CEB_REG_HEAD 8'h08
`define CEB_REG_BASE 8'h0C
`define CEB_REG_STAT 8'h10
`define CEB_REG_CNT 8'h14
`define CEB_CTRL_EN 0
`define CEB_CTRL_ADMIN 1
`define CEB_SIZE_RESET 16'h000F
`define CEB_SIZE_MIN 16'h0001
`define CEB_SIZE_MAX_ADMIN 16'h0FFF
`define CEB_SIZE_MAX_IO 16'hFFFF
`define CEB_REC_BYTES 16
`define CEB_REC_WORDS 4
`define CEB_TYPE_GENERIC 3'h0
`define CEB_TYPE_CMD 3'h1
`define CEB_TYPE_MEDIA 3'h2
`define CEB_TYPE_VENDOR 3'h7
`define CEB_SC_SUCCESS 8'h00
`define CEB_SC_GEN_LAST 8'h0B
`define CEB_SC_INTERNAL 8'h06
`define CEB_SC_IOSET 8'h80
`define CEB_SC_GEN_IO_LAST 8'h82
`define CEB_SC_CMD_LAST 8'h0A
`define CEB_SC_CMD_IO_LAST 8'h80
`define CEB_SC_MEDIA_IO_LAST 8'h86
`define CEB_SC_SHARED_LAST 8'h7F
`define CEB_SC_VENDOR 8'hC0
`define CEB_RESP_OKAY 2'h0
`define CEB_RESP_SLVERR 2'h2
`endif

// ===== src/ceb_completion_builder.v
// completion record builder with AXI4-Lite control registers
`timescale 1ns/1ps
`include "ceb_regs.vh"
module ceb_completion_builder #(
  parameter ADDR_W = 32
)(
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // register bus write
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // register bus read
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // completion request from the command engine
  input wire req_valid,
  output wire req_ready,
  input wire [31:0] req_result,
  input wire [15:0] req_source_ring_id,
  input wire [15:0] req_source_ring_consume_ptr,
  input wire [15:0] req_command_tag,
  input wire req_retry_futile,
  input wire req_more_info,
  input wire req_timed_abort,
  input wire [2:0] req_status_type,
  input wire [7:0] req_code_a,
  input wire [7:0] req_code_b,
  input wire req_code_b_valid,
  // record write stream toward host memory
  output reg wr_valid,
  input wire wr_ready,
  output reg [ADDR_W-1:0] wr_addr,
  output reg [31:0] wr_data,
  output reg wr_last,
  // ring state
  output wire controller_enable_bit,
  output wire ring_full
);

  reg [1:0] ctrl_reg;
  reg [15:0] size_reg;
  reg [15:0] head_reg;
  reg [31:0] base_reg;
  reg [15:0] tail_reg;
  reg phase_reg;
  reg [31:0] cnt_reg;
  reg busy_reg;
  reg [1:0] word_reg;
  reg [31:0] rec_reg [0:3];
  reg en_prev_reg;
  reg [15:0] tail_inc;
  reg [15:0] size_wr;
  reg [15:0] size_max;
  reg [7:0] code_min;
  reg [2:0] type_out;
  reg [7:0] code_out;
  reg retry_out;
  reg more_out;
  reg known;
  reg [31:0] rd_mux;
  reg rd_ok;
  reg wr_ok;
  wire wr_take;
  wire rd_take;
  wire req_take;
  wire enable;
  wire [31:0] wmask;
  wire [15:0] size_merged;
  wire [15:0] head_merged;
  wire [31:0] base_merged;

  assign enable = ctrl_reg[`CEB_CTRL_EN];
  assign controller_enable_bit = enable;

  // bus write: address and data taken together, one response at a time
  assign wr_take = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wr_take;
  assign s_axi_wready = wr_take;
  assign rd_take = s_axi_arvalid & ~s_axi_rvalid;
  assign s_axi_arready = rd_take;
  assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                  {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

  // byte-lane merges for the size, head and base registers
  ceb_lane_merge #(.W(16)) u_size_merge (
    .old_value(size_reg),
    .bus_data(s_axi_wdata[15:0]),
    .bus_mask(wmask[15:0]),
    .merged(size_merged)
  );
  ceb_lane_merge #(.W(16)) u_head_merge (
    .old_value(head_reg),
    .bus_data(s_axi_wdata[15:0]),
    .bus_mask(wmask[15:0]),
    .merged(head_merged)
  );
  ceb_lane_merge #(.W(32)) u_base_merge (
    .old_value(base_reg),
    .bus_data(s_axi_wdata),
    .bus_mask(wmask),
    .merged(base_merged)
  );

  // ring size clamp: zero-based, two slots least, admin ring smaller
  always @*
  begin
    size_max = ctrl_reg[`CEB_CTRL_ADMIN] ? `CEB_SIZE_MAX_ADMIN : `CEB_SIZE_MAX_IO;
    size_wr = size_merged;
    if (size_wr < `CEB_SIZE_MIN)
      size_wr = `CEB_SIZE_MIN;
    if (size_wr > size_max)
      size_wr = size_max;
  end

  // next producer slot, wrapping after the last slot
  always @*
  begin
    if (tail_reg >= size_reg)
      tail_inc = 16'h0000;
    else
      tail_inc = tail_reg + 16'h0001;
  end

  // one slot stays unused: full when the next slot is the consumer's
  assign ring_full = (tail_inc == head_reg);
  assign req_ready = enable & ~busy_reg & ~ring_full;
  assign req_take = req_valid & req_ready;

  // smallest applicable code wins
  always @*
  begin
    if (req_code_b_valid && (req_code_b < req_code_a))
      code_min = req_code_b;
    else
      code_min = req_code_a;
  end

  // status word: known codes pass, anything unknown reports internal error
  always @*
  begin
    known = 1'b0;
    if (code_min >= `CEB_SC_VENDOR)
      known = 1'b1;
    case (req_status_type)
      `CEB_TYPE_GENERIC:
      begin
        if (code_min <= `CEB_SC_GEN_LAST)
          known = 1'b1;
        if ((code_min >= `CEB_SC_IOSET) && (code_min <= `CEB_SC_GEN_IO_LAST))
          known = 1'b1;
      end
      `CEB_TYPE_CMD:
      begin
        if (code_min <= `CEB_SC_CMD_LAST)
          known = 1'b1;
        if (code_min == `CEB_SC_CMD_IO_LAST)
          known = 1'b1;
      end
      `CEB_TYPE_MEDIA:
      begin
        if ((code_min >= `CEB_SC_IOSET) && (code_min <= `CEB_SC_MEDIA_IO_LAST))
          known = 1'b1;
      end
      `CEB_TYPE_VENDOR:
        known = 1'b1;
      default:
        known = 1'b0;
    endcase
    type_out = req_status_type;
    code_out = code_min;
    retry_out = req_retry_futile;
    more_out = req_more_info;
    if (!known)
    begin
      type_out = `CEB_TYPE_GENERIC;
      code_out = `CEB_SC_INTERNAL;
    end
    if (req_timed_abort)
      retry_out = 1'b0;
    if (known && (type_out == `CEB_TYPE_GENERIC) && (code_out == `CEB_SC_SUCCESS))
    begin
      retry_out = 1'b0;
      more_out = 1'b0;
    end
  end

  // registers, ring pointers and record emission
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg <= 2'h0;
      size_reg <= `CEB_SIZE_RESET;
      head_reg <= 16'h0000;
      base_reg <= 32'h00000000;
      tail_reg <= 16'h0000;
      phase_reg <= 1'b1;
      cnt_reg <= 32'h00000000;
      busy_reg <= 1'b0;
      word_reg <= 2'h0;
      en_prev_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CEB_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `CEB_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      wr_valid <= 1'b0;
      wr_addr <= {ADDR_W{1'b0}};
      wr_data <= 32'h00000000;
      wr_last <= 1'b0;
      rec_reg[0] <= 32'h00000000;
      rec_reg[1] <= 32'h00000000;
      rec_reg[2] <= 32'h00000000;
      rec_reg[3] <= 32'h00000000;
    end
    else
    begin
      en_prev_reg <= enable;
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_take)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `CEB_RESP_OKAY : `CEB_RESP_SLVERR;
        case (s_axi_awaddr)
          `CEB_REG_CTRL:
            if (s_axi_wstrb[0])
              ctrl_reg <= s_axi_wdata[1:0];
          `CEB_REG_SIZE:
            if (!enable)
              size_reg <= size_wr;
          `CEB_REG_HEAD:
            head_reg <= head_merged;
          `CEB_REG_BASE:
            base_reg <= base_merged;
          default:
            ctrl_reg <= ctrl_reg;
        endcase
      end
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (rd_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? `CEB_RESP_OKAY : `CEB_RESP_SLVERR;
      end
      // enable edge: host has cleared all freshness bits, first pass writes one
      if (enable && !en_prev_reg)
      begin
        tail_reg <= 16'h0000;
        head_reg <= 16'h0000;
        phase_reg <= 1'b1;
      end
      if (req_take)
      begin
        rec_reg[0] <= req_result;
        rec_reg[1] <= 32'h00000000;
        rec_reg[2] <= {req_source_ring_id, req_source_ring_consume_ptr};
        rec_reg[3] <= {retry_out, more_out, 2'b00, type_out, code_out,
                       phase_reg, req_command_tag};
        busy_reg <= 1'b1;
        word_reg <= 2'h0;
        wr_valid <= 1'b1;
        wr_addr <= base_reg[ADDR_W-1:0] + {{(ADDR_W-20){1'b0}}, tail_reg, 4'h0};
        wr_data <= req_result;
        wr_last <= 1'b0;
      end
      else if (wr_valid && wr_ready)
      begin
        if (wr_last)
        begin
          wr_valid <= 1'b0;
          wr_last <= 1'b0;
          busy_reg <= 1'b0;
          cnt_reg <= cnt_reg + 32'h00000001;
          tail_reg <= tail_inc;
          if (tail_inc == 16'h0000)
            phase_reg <= ~phase_reg;
        end
        else
        begin
          word_reg <= word_reg + 2'h1;
          wr_addr <= wr_addr + {{(ADDR_W-3){1'b0}}, 3'h4};
          wr_data <= rec_reg[word_reg + 2'h1];
          wr_last <= (word_reg == 2'h2);
        end
      end
    end
  end

  // write and read decode
  always @*
  begin
    wr_ok = 1'b1;
    case (s_axi_awaddr)
      `CEB_REG_CTRL, `CEB_REG_SIZE, `CEB_REG_HEAD, `CEB_REG_BASE:
        wr_ok = 1'b1;
      default:
        wr_ok = 1'b0;
    endcase
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `CEB_REG_CTRL:
        rd_mux = {30'h0, ctrl_reg};
      `CEB_REG_SIZE:
        rd_mux = {16'h0000, size_reg};
      `CEB_REG_HEAD:
        rd_mux = {16'h0000, head_reg};
      `CEB_REG_BASE:
        rd_mux = base_reg;
      `CEB_REG_STAT:
        rd_mux = {13'h0, ring_full, busy_reg, phase_reg, tail_reg};
      `CEB_REG_CNT:
        rd_mux = cnt_reg;
      default:
      begin
        rd_mux = 32'h00000000;
        rd_ok = 1'b0;
      end
    endcase
  end

endmodule

// byte-lane merge of a bus write into a register
module ceb_lane_merge #(
  parameter W = 32
)(
  // old value, bus word and byte-lane mask
  input wire [W-1:0] old_value,
  input wire [W-1:0] bus_data,
  input wire [W-1:0] bus_mask,
  // merged value
  output wire [W-1:0] merged
);
  assign merged = (bus_data & bus_mask) | (old_value & ~bus_mask);
endmodule

// ===== tb/ceb_checker_sva.sv
// port assertions for the completion record builder
`timescale 1ns/1ps
module ceb_checker #(
  parameter ADDR_W = 32
)(
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // register bus handshakes
  input wire s_axi_awvalid,
  input wire s_axi_wvalid,
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  // request and record stream
  input wire req_valid,
  input wire req_ready,
  input wire wr_valid,
  input wire wr_ready,
  input wire [ADDR_W-1:0] wr_addr,
  input wire [31:0] wr_data,
  input wire wr_last,
  input wire controller_enable_bit
);
  logic [1:0] widx_reg;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // index of the word now offered
  always @(posedge aclk)
  begin
    if (!aresetn)
      widx_reg <= 2'h0;
    else if (wr_valid && wr_ready)
      widx_reg <= widx_reg + 2'h1;
  end
  sequence s_take;
    req_valid && req_ready;
  endsequence
  sequence s_beat;
    wr_valid && wr_ready && !wr_last;
  endsequence
  a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write response missing");
  a_gate_enable: assert property (!controller_enable_bit |-> !req_ready)
    else $error("request taken while disabled");
  a_record_start: assert property (s_take |=> wr_valid && widx_reg == 2'h0)
    else $error("record did not start");
  a_word_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_data))
    else $error("word changed before accept");
  a_word_one: assert property (wr_valid && widx_reg == 2'h1 |-> wr_data == 32'h0)
    else $error("word one not zero");
  a_last_word: assert property (wr_valid |-> wr_last == (widx_reg == 2'h3))
    else $error("last flag misplaced");
  a_addr_step: assert property (s_beat |=> wr_addr == $past(wr_addr) + 4)
    else $error("address step wrong");
  a_status_resv: assert property (wr_valid && widx_reg == 2'h3 |-> wr_data[29:28] == 2'h0)
    else $error("reserved status bits set");
  a_busy_refuse: assert property (wr_valid |-> !req_ready)
    else $error("request taken mid record");
endmodule
bind ceb_completion_builder ceb_checker #(.ADDR_W(ADDR_W)) u_chk (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_wvalid, .s_axi_awready, .s_axi_bvalid, .req_valid, .req_ready,
  .wr_valid, .wr_ready, .wr_addr, .wr_data, .wr_last, .controller_enable_bit);

// ===== tb/ceb_host_mem.sv
// host memory model taking record words
`timescale 1ns/1ps
module ceb_host_mem (
  // clock
  input wire aclk,
  // record write stream
  input wire wr_valid,
  output logic wr_ready,
  input wire [31:0] wr_addr,
  input wire [31:0] wr_data,
  // stall control
  input wire stall
);
  // four slots of four words at the ring base; writes elsewhere are dropped
  logic [31:0] mem [0:15];
  initial
  begin
    wr_ready = 1'h0;
    for (int i = 0; i < 16; i++)
      mem[i] = 32'h0;
  end
  function automatic logic [31:0] rd(input logic [31:0] a);
    return (a[31:6] == 26'h40) ? mem[a[5:2]] : 32'h0;
  endfunction
  always @(posedge aclk)
  begin
    if (wr_valid && wr_ready && wr_addr[31:6] == 26'h40)
      mem[wr_addr[5:2]] = wr_data;
    wr_ready <= stall ? !wr_ready : 1'h1;
  end
endmodule

// ===== tb/testbench.sv
// self-checking bench for the completion record builder
`timescale 1ns/1ps
module testbench;
  logic aclk = 1'h0, aresetn = 1'h0, stall = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, req_code_a = 8'h0, req_code_b = 8'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, req_status_type = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, req_result = 32'h0, q;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, req_valid = 1'h0, req_code_b_valid = 1'h0;
  logic req_retry_futile = 1'h0, req_more_info = 1'h0, req_timed_abort = 1'h0, ph = 1'h1;
  logic [15:0] req_source_ring_id = 16'h0, req_source_ring_consume_ptr = 16'h0;
  logic [15:0] req_command_tag = 16'h0;
  logic [7:0] k = 8'h0;
  logic [1:0] r;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, req_ready;
  wire wr_valid, wr_ready, wr_last, controller_enable_bit, ring_full;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, wr_addr, wr_data;
  integer errors = 0, checked = 0, cyc = 0, slot = 0, hd = 0;
  ceb_completion_builder u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .req_valid, .req_ready, .req_result,
    .req_source_ring_id, .req_source_ring_consume_ptr, .req_command_tag, .req_retry_futile,
    .req_more_info, .req_timed_abort, .req_status_type, .req_code_a, .req_code_b,
    .req_code_b_valid, .wr_valid, .wr_ready, .wr_addr, .wr_data, .wr_last,
    .controller_enable_bit, .ring_full);
  ceb_host_mem u_mem (.aclk, .wr_valid, .wr_ready, .wr_addr, .wr_data, .stall);
  initial forever #50 aclk = ~aclk;
  task automatic conclude();
    $display("compares %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input [31:0] got, input [31:0] exp);
    checked = checked + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one register access; w selects write
  task automatic axi(input w, input [7:0] a, input [31:0] d);
    @(posedge aclk);
    if (w)
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
    else
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do @(negedge aclk); while (!(w ? s_axi_awready : s_axi_arready));
    @(posedge aclk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= 3'h0;
    do @(negedge aclk); while (!(w ? s_axi_bvalid : s_axi_rvalid));
    q = s_axi_rdata;
    r = w ? s_axi_bresp : s_axi_rresp;
    @(posedge aclk);
    {s_axi_bready, s_axi_rready} <= 2'h0;
  endtask
  // post one record and compare the four words in host memory
  task automatic rec(input [2:0] ty, input [7:0] a, b, input bv, rt, mo, ta, input [14:0] st);
    logic [31:0] base;
    @(posedge aclk);
    base = 32'h1000 + slot * 16;
    {req_status_type, req_code_a, req_code_b, req_code_b_valid} <= {ty, a, b, bv};
    {req_retry_futile, req_more_info, req_timed_abort, stall, req_valid} <= {rt, mo, ta, k[0], 1'h1};
    {req_source_ring_id, req_source_ring_consume_ptr} <= {8'h01, k, 8'h02, k};
    {req_command_tag, req_result} <= {8'hA0, k, 24'hC0DE00, k};
    do @(negedge aclk); while (!req_ready);
    @(posedge aclk);
    req_valid <= 1'h0;
    do @(negedge aclk); while (!(wr_valid && wr_ready && wr_last));
    repeat (2) @(negedge aclk);
    chk(u_mem.rd(base), {24'hC0DE00, k});
    chk(u_mem.rd(base + 4), 32'h0);
    chk(u_mem.rd(base + 8), {8'h01, k, 8'h02, k});
    chk(u_mem.rd(base + 12), {st, ph, 8'hA0, k});
    slot = (slot + 1) % 4;
    ph = (slot == 0) ? !ph : ph;
    chk(ring_full, ((slot + 1) % 4) == hd);
    if (((slot + 1) % 4) == hd)
    begin
      axi(0, 8'h10, 32'h0);
      chk(q, {13'h0, 1'b1, 1'b0, ph, slot[15:0]});
      hd = slot;
      axi(1, 8'h08, hd);
    end
    k = k + 8'h1;
  endtask
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      errors = errors + 1;
      conclude();
    end
  end
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    axi(0, 8'h04, 32'h0);
    chk(q, 32'h000F);
    axi(0, 8'h10, 32'h0);
    chk(q, 32'h00010000);
    axi(0, 8'h20, 32'h0);
    chk(q, 32'h0);
    chk(r, 32'h2);
    axi(1, 8'h20, 32'h5);
    chk(r, 32'h2);
    axi(1, 8'h00, 32'h2);
    chk(r, 32'h0);
    axi(1, 8'h04, 32'hFFFF);
    axi(0, 8'h04, 32'h0);
    chk(q, 32'h0FFF);
    axi(1, 8'h04, 32'h0);
    axi(0, 8'h04, 32'h0);
    chk(q, 32'h1);
    axi(1, 8'h04, 32'h3);
    axi(1, 8'h0C, 32'h1000);
    axi(1, 8'h00, 32'h1);
    axi(1, 8'h04, 32'h7);
    axi(0, 8'h04, 32'h0);
    chk(q, 32'h3);
    rec(3'h0, 8'h00, 8'h00, 1'h0, 1'h1, 1'h1, 1'h0, 15'h0000);
    rec(3'h0, 8'h05, 8'h02, 1'h1, 1'h1, 1'h0, 1'h0, 15'h4002);
    rec(3'h1, 8'h08, 8'h00, 1'h0, 1'h0, 1'h1, 1'h0, 15'h2108);
    rec(3'h2, 8'h86, 8'h00, 1'h0, 1'h1, 1'h0, 1'h1, 15'h0286);
    rec(3'h7, 8'hC5, 8'h00, 1'h0, 1'h0, 1'h0, 1'h0, 15'h07C5);
    rec(3'h4, 8'h01, 8'h00, 1'h0, 1'h0, 1'h0, 1'h0, 15'h0006);
    rec(3'h0, 8'h82, 8'h00, 1'h0, 1'h1, 1'h0, 1'h0, 15'h4082);
    rec(3'h1, 8'h81, 8'h00, 1'h0, 1'h0, 1'h0, 1'h0, 15'h0006);
    axi(0, 8'h14, 32'h0);
    chk(q, 32'h8);
    conclude();
  end
endmodule
